// File: hdl/csb_pkg.sv
// Package: operation codes, flag positions and carriers for the compare/skip/branch unit
package csb_pkg;
	// ------------------------------------------------------------
	// Widths and flag positions
	// ------------------------------------------------------------
	localparam int CSB_PC_W = 16;
	localparam int CSB_FLAG_C = 0;
	localparam int CSB_FLAG_Z = 1;
	localparam int CSB_FLAG_N = 2;
	localparam int CSB_FLAG_V = 3;
	localparam int CSB_FLAG_S = 4;
	localparam int CSB_FLAG_H = 5;
	localparam logic [7:0] CSB_FLAGS_RST = 8'h00;
	localparam logic [15:0] CSB_PC_RST = 16'h0000;
	localparam logic [15:0] CSB_PC_ONE = 16'h0001;
	localparam logic [15:0] CSB_PC_TWO = 16'h0002;
	localparam logic [15:0] CSB_PC_THREE = 16'h0003;
	localparam logic [1:0] CSB_CYC_ONE = 2'h1;
	localparam logic [1:0] CSB_CYC_TWO = 2'h2;
	localparam logic [1:0] CSB_CYC_THREE = 2'h3;

	// ------------------------------------------------------------
	// Operations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CSB_OP_NOP = 4'h0,
		CSB_OP_CMP = 4'h1,
		CSB_OP_CMP_CARRY = 4'h2,
		CSB_OP_CMP_IMM = 4'h3,
		CSB_OP_SKIP_REG_CLR = 4'h4,
		CSB_OP_SKIP_REG_SET = 4'h5,
		CSB_OP_SKIP_IO_CLR = 4'h6,
		CSB_OP_SKIP_IO_SET = 4'h7,
		CSB_OP_BR_FLAG_SET = 4'h8,
		CSB_OP_BR_FLAG_CLR = 4'h9,
		CSB_OP_BR_EQ = 4'hA,
		CSB_OP_BR_NE = 4'hB,
		CSB_OP_BR_CS = 4'hC
	} csb_op_e;

	typedef enum logic [2:0] {
		CSB_ST_IDLE = 3'b001,
		CSB_ST_BUSY = 3'b010,
		CSB_ST_DONE = 3'b100
	} csb_state_e;

	// ------------------------------------------------------------
	// Instruction carrier
	// ------------------------------------------------------------
	typedef struct packed {
		csb_op_e op;
		logic [7:0] reg_a;
		logic [7:0] reg_b;
		logic [7:0] io_val;
		logic [2:0] sel;
		logic signed [6:0] offset;
		logic next_is_long;
	} csb_instr_s;
endpackage

// File: hdl/csb_unit.sv
// Compare, bit-test skip and conditional branch execution unit
//
// Notes on behaviour
// - Register compare subtracts the second register from the first, sets Z N V C H, keeps no result, one cycle.
// - Compare with carry subtracts the second register and carry, sets Z N V C H, keeps no result, one cycle.
// - Immediate compare subtracts a constant from a register, sets Z N V C H, one cycle.
// - Skip on register bit clear advances the PC by two or three when the bit is zero, in 1 to 3 cycles.
// - Skip on register bit set advances the PC by two or three when the bit is one, in 1 to 3 cycles.
// - Skip on I/O bit clear advances the PC by two or three when the bit is zero, flags kept.
// - Skip on I/O bit set advances the PC by two or three when the bit is one, flags kept.
// - Branch on flag set loads PC plus offset plus one when the chosen flag is one, 1 or 2 cycles.
// - Branch on flag clear loads PC plus offset plus one when the chosen flag is zero, 1 or 2 cycles.
// - Branch if equal jumps to PC plus offset plus one when Z is one, flags kept.
// - Branch if not equal jumps to PC plus offset plus one when Z is zero, flags kept.
// - Branch if carry set jumps to PC plus offset plus one when C is one, flags kept.
`timescale 1ns/100ps
`default_nettype none
module csb_unit (
	input wire logic CLK_IN, // 200 MHz core clock
	input wire logic RESETN_IN, // Asynchronous reset, active low
	input wire logic ISSUE_IN, // Instruction valid, one-cycle pulse
	input wire csb_pkg::csb_instr_s INSTR_IN, // Decoded instruction
	output logic READY_OUT, // Unit can accept an instruction
	output logic DONE_OUT, // Instruction retired, one-cycle pulse
	output logic [15:0] PC_OUT, // Program counter in words
	output logic [7:0] FLAGS_OUT // status_flags_register
);
	import csb_pkg::*;

	csb_state_e state;
	logic [1:0] wait_cnt;
	logic [15:0] next_pc;
	logic [7:0] next_flags;
	logic [1:0] next_cycles;
	logic [8:0] diff;
	logic [7:0] sub_b;
	logic cin, taken, is_cmp;

	// ------------------------------------------------------------
	// Subtractor and condition evaluation
	// ------------------------------------------------------------
	always_comb begin
		sub_b = INSTR_IN.reg_b;
		cin = 1'b0;
		is_cmp = 1'b0;
		taken = 1'b0;
		case (INSTR_IN.op)
			CSB_OP_CMP: is_cmp = 1'b1;
			CSB_OP_CMP_CARRY: begin
				is_cmp = 1'b1;
				cin = FLAGS_OUT[CSB_FLAG_C];
			end
			CSB_OP_CMP_IMM: is_cmp = 1'b1;
			CSB_OP_SKIP_REG_CLR: taken = ~INSTR_IN.reg_a[INSTR_IN.sel];
			CSB_OP_SKIP_REG_SET: taken = INSTR_IN.reg_a[INSTR_IN.sel];
			CSB_OP_SKIP_IO_CLR: taken = ~INSTR_IN.io_val[INSTR_IN.sel];
			CSB_OP_SKIP_IO_SET: taken = INSTR_IN.io_val[INSTR_IN.sel];
			CSB_OP_BR_FLAG_SET: taken = FLAGS_OUT[INSTR_IN.sel];
			CSB_OP_BR_FLAG_CLR: taken = ~FLAGS_OUT[INSTR_IN.sel];
			CSB_OP_BR_EQ: taken = FLAGS_OUT[CSB_FLAG_Z];
			CSB_OP_BR_NE: taken = ~FLAGS_OUT[CSB_FLAG_Z];
			CSB_OP_BR_CS: taken = FLAGS_OUT[CSB_FLAG_C];
			default: taken = 1'b0;
		endcase
		diff = {1'b0, INSTR_IN.reg_a} - {1'b0, sub_b} - {8'h00, cin};
	end

	// ------------------------------------------------------------
	// Next PC, flags and cycle count
	// ------------------------------------------------------------
	always_comb begin
		next_pc = PC_OUT + CSB_PC_ONE;
		next_flags = FLAGS_OUT;
		next_cycles = CSB_CYC_ONE;
		if (is_cmp) begin
			next_flags[CSB_FLAG_C] = diff[8];
			next_flags[CSB_FLAG_N] = diff[7];
			next_flags[CSB_FLAG_V] = (INSTR_IN.reg_a[7] ^ sub_b[7])
				& (INSTR_IN.reg_a[7] ^ diff[7]);
			next_flags[CSB_FLAG_S] = diff[7] ^ next_flags[CSB_FLAG_V];
			next_flags[CSB_FLAG_H] = (~INSTR_IN.reg_a[3] & sub_b[3])
				| (sub_b[3] & diff[3]) | (diff[3] & ~INSTR_IN.reg_a[3]);
			// Compare with carry only keeps Z clear, never sets it
			if (INSTR_IN.op == CSB_OP_CMP_CARRY) begin
				next_flags[CSB_FLAG_Z] = (diff[7:0] == 8'h00)
					& FLAGS_OUT[CSB_FLAG_Z];
			end else begin
				next_flags[CSB_FLAG_Z] = (diff[7:0] == 8'h00);
			end
		end else if (taken && INSTR_IN.op inside {CSB_OP_SKIP_REG_CLR,
			CSB_OP_SKIP_REG_SET, CSB_OP_SKIP_IO_CLR, CSB_OP_SKIP_IO_SET}) begin
			next_pc = PC_OUT + (INSTR_IN.next_is_long ? CSB_PC_THREE
				: CSB_PC_TWO);
			next_cycles = INSTR_IN.next_is_long ? CSB_CYC_THREE
				: CSB_CYC_TWO;
		end else if (taken) begin
			next_pc = PC_OUT + {{9{INSTR_IN.offset[6]}}, INSTR_IN.offset}
				+ CSB_PC_ONE;
			next_cycles = CSB_CYC_TWO;
		end
	end

	// ------------------------------------------------------------
	// Architectural state update
	// ------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PC_OUT <= CSB_PC_RST;
			FLAGS_OUT <= CSB_FLAGS_RST;
		end else if (ISSUE_IN && READY_OUT) begin
			PC_OUT <= next_pc;
			FLAGS_OUT <= next_flags;
		end
	end

	// ------------------------------------------------------------
	// Cycle sequencing
	// ------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state <= CSB_ST_IDLE;
			wait_cnt <= 2'h0;
			READY_OUT <= 1'b1;
			DONE_OUT <= 1'b0;
		end else begin
			DONE_OUT <= 1'b0;
			case (state)
				CSB_ST_IDLE: begin
					if (ISSUE_IN) begin
						if (next_cycles == CSB_CYC_ONE) begin
							DONE_OUT <= 1'b1;
						end else begin
							state <= CSB_ST_BUSY;
							READY_OUT <= 1'b0;
							wait_cnt <= next_cycles - CSB_CYC_TWO;
						end
					end
				end
				CSB_ST_BUSY: begin
					if (wait_cnt == 2'h0) begin
						state <= CSB_ST_IDLE;
						READY_OUT <= 1'b1;
						DONE_OUT <= 1'b1;
					end else begin
						wait_cnt <= wait_cnt - 2'h1;
					end
				end
				default: begin
					state <= CSB_ST_IDLE;
					READY_OUT <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	wire accept = ISSUE_IN && READY_OUT;
	wire is_branch = INSTR_IN.op inside {CSB_OP_BR_FLAG_SET, CSB_OP_BR_FLAG_CLR,
		CSB_OP_BR_EQ, CSB_OP_BR_NE, CSB_OP_BR_CS};
	wire is_skip = INSTR_IN.op inside {CSB_OP_SKIP_REG_CLR, CSB_OP_SKIP_REG_SET,
		CSB_OP_SKIP_IO_CLR, CSB_OP_SKIP_IO_SET};

	a_cmp_one_cycle: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && is_cmp |=> DONE_OUT && READY_OUT && PC_OUT == $past(PC_OUT) + 16'h0001)
		else $error("compare did not retire in one cycle");
	a_cmp_zero_flag: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && INSTR_IN.op == CSB_OP_CMP_IMM && INSTR_IN.reg_a == INSTR_IN.reg_b
		|=> FLAGS_OUT[CSB_FLAG_Z] && !FLAGS_OUT[CSB_FLAG_C])
		else $error("equal compare did not set zero");
	a_cmpc_borrow: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && INSTR_IN.op == CSB_OP_CMP_CARRY && FLAGS_OUT[CSB_FLAG_C]
		&& INSTR_IN.reg_a == INSTR_IN.reg_b |=> FLAGS_OUT[CSB_FLAG_C])
		else $error("compare with carry lost the borrow");
	a_skip_long: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && is_skip && taken && INSTR_IN.next_is_long
		|=> !READY_OUT ##1 !READY_OUT ##1 READY_OUT && DONE_OUT)
		else $error("long skip did not take three cycles");
	a_skip_pc: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && is_skip && taken |=> PC_OUT - $past(PC_OUT)
		== ($past(INSTR_IN.next_is_long) ? 16'h0003 : 16'h0002))
		else $error("skip moved the PC wrongly");
	a_skip_flags: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && (is_skip || is_branch) |=> $stable(FLAGS_OUT))
		else $error("skip or branch changed the flags");
	a_branch_target: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && is_branch && taken |=> PC_OUT == $past(PC_OUT)
		+ {{9{$past(INSTR_IN.offset[6])}}, $past(INSTR_IN.offset)} + 16'h0001)
		else $error("branch target wrong");
	a_branch_two: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && is_branch && taken |=> !READY_OUT ##1 DONE_OUT)
		else $error("taken branch did not take two cycles");
	a_false_one: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && (is_skip || is_branch) && !taken
		|=> DONE_OUT && PC_OUT == $past(PC_OUT) + 16'h0001)
		else $error("false condition did not advance by one");
	a_ne_cond: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && INSTR_IN.op == CSB_OP_BR_NE && FLAGS_OUT[CSB_FLAG_Z]
		|=> PC_OUT == $past(PC_OUT) + 16'h0001)
		else $error("not-equal branch taken with zero set");
	a_cs_cond: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && INSTR_IN.op == CSB_OP_BR_CS && !FLAGS_OUT[CSB_FLAG_C]
		|=> PC_OUT == $past(PC_OUT) + 16'h0001)
		else $error("carry branch taken with carry clear");
	a_clr_cond: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && INSTR_IN.op == CSB_OP_BR_FLAG_CLR && FLAGS_OUT[INSTR_IN.sel]
		|=> PC_OUT == $past(PC_OUT) + 16'h0001)
		else $error("flag-clear branch taken with flag set");
	a_reg_set_cond: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		accept && INSTR_IN.op == CSB_OP_SKIP_REG_SET && !INSTR_IN.reg_a[INSTR_IN.sel]
		|=> DONE_OUT)
		else $error("register-set skip taken with bit clear");

	c_cmp: cover property (@(posedge CLK_IN) accept && is_cmp);
	c_skip_long: cover property (@(posedge CLK_IN) accept && is_skip && taken
		&& INSTR_IN.next_is_long);
	c_branch_back: cover property (@(posedge CLK_IN) accept && is_branch && taken
		&& INSTR_IN.offset[6]);
	c_branch_not: cover property (@(posedge CLK_IN) accept && is_branch && !taken);
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench for the compare, skip and branch unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import csb_pkg::*;
	logic CLK_IN, RESETN_IN, ISSUE_IN, READY_OUT, DONE_OUT;
	csb_instr_s INSTR_IN;
	logic [15:0] PC_OUT, ep;
	logic [7:0] FLAGS_OUT, ef;
	int errors = 0, total_checks = 0, cycles = 0;
	csb_unit u_csb_unit (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
		.ISSUE_IN(ISSUE_IN), .INSTR_IN(INSTR_IN), .READY_OUT(READY_OUT),
		.DONE_OUT(DONE_OUT), .PC_OUT(PC_OUT), .FLAGS_OUT(FLAGS_OUT));
	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	initial begin
		CLK_IN = 1'b0;
		forever #2.5 CLK_IN = ~CLK_IN;
	end
	always @(posedge CLK_IN) begin
		cycles++;
		if (cycles >= 20000) begin
			errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flags of a - b - ci; with keep clear, Z is forced clear
	function automatic logic [7:0] fl(input logic [7:0] a, b,
			input logic ci, keep);
		logic [7:0] r;
		logic c, h, v, z;
		r = a - b - {7'h00, ci};
		c = ({1'b0, a} < ({1'b0, b} + {8'h00, ci}));
		h = ({1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, ci}));
		v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		z = (r == 8'h00) & keep;
		return {2'b00, h, r[7] ^ v, v, r[7], z, c};
	endfunction
	// Issue one instruction, predict and judge its outcome
	task automatic ex(input csb_op_e op, input logic [7:0] a, b, io,
			input logic [2:0] s, input logic [6:0] off, input logic lg,
			input bit poke);
		int cy, n;
		logic t, sk;
		cy = 1;
		t = 1'b0;
		sk = 1'b0;
		case (op)
			CSB_OP_CMP: ef = fl(a, b, 1'b0, 1'b1);
			CSB_OP_CMP_CARRY: ef = fl(a, b, ef[0], ef[1]);
			CSB_OP_CMP_IMM: ef = fl(a, b, 1'b0, 1'b1);
			CSB_OP_SKIP_REG_CLR: begin t = !a[s]; sk = 1'b1; end
			CSB_OP_SKIP_REG_SET: begin t = a[s]; sk = 1'b1; end
			CSB_OP_SKIP_IO_CLR: begin t = !io[s]; sk = 1'b1; end
			CSB_OP_SKIP_IO_SET: begin t = io[s]; sk = 1'b1; end
			CSB_OP_BR_FLAG_SET: t = ef[s];
			CSB_OP_BR_FLAG_CLR: t = !ef[s];
			CSB_OP_BR_EQ: t = ef[1];
			CSB_OP_BR_NE: t = !ef[1];
			CSB_OP_BR_CS: t = ef[0];
			default: t = 1'b0;
		endcase
		if (t && sk) begin
			cy = lg ? 3 : 2;
			ep = ep + 16'(cy);
		end else if (t) begin
			cy = 2;
			ep = ep + {{9{off[6]}}, off} + 16'h0001;
		end else
			ep = ep + 16'h0001;
		@(negedge CLK_IN);
		ISSUE_IN = 1'b1;
		INSTR_IN = '{op:op, reg_a:a, reg_b:b, io_val:io, sel:s,
			offset:off, next_is_long:lg};
		@(negedge CLK_IN);
		n = 1;
		if (poke && cy > 1)
			INSTR_IN = '{op:CSB_OP_CMP, reg_a:8'h00, reg_b:8'h01,
				io_val:8'h00, sel:3'h0, offset:7'h00, next_is_long:1'b0};
		else
			ISSUE_IN = 1'b0;
		if (cy > 1)
			chk({15'h0000, READY_OUT}, 16'h0000);
		while (DONE_OUT !== 1'b1 && n < 8) begin
			@(negedge CLK_IN);
			ISSUE_IN = 1'b0;
			n++;
		end
		chk(16'(n), 16'(cy));
		chk({15'h0000, READY_OUT}, 16'h0001);
		chk(PC_OUT, ep);
		chk({8'h00, FLAGS_OUT}, {8'h00, ef});
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_cmp();
		logic [7:0] av[5] = '{8'h00, 8'h80, 8'h10, 8'h7F, 8'h05};
		logic [7:0] bv[5] = '{8'h00, 8'h01, 8'h20, 8'hFF, 8'h05};
		for (int k = 0; k < 5; k++) begin
			ex(CSB_OP_CMP, av[k], bv[k], 8'h00, 3'h0, 7'h00, 1'b0, 0);
			ex(CSB_OP_CMP_CARRY, av[k], bv[k], 8'h00, 3'h0, 7'h00, 1'b0, 0);
			ex(CSB_OP_CMP_IMM, av[k], bv[k], 8'h00, 3'h0, 7'h00, 1'b0, 0);
		end
		ex(CSB_OP_CMP, 8'h10, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0, 0);
		ex(CSB_OP_CMP_CARRY, 8'h21, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0, 0);
		// Borrow in with equal operands must propagate a borrow out
		ex(CSB_OP_CMP, 8'h10, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0, 0);
		ex(CSB_OP_CMP_CARRY, 8'h33, 8'h33, 8'h00, 3'h0, 7'h00, 1'b0, 0);
	endtask
	task automatic t_skip();
		for (int k = 4; k < 8; k++)
			for (int s = 0; s < 8; s++)
				ex(csb_op_e'(k), 8'hA5, 8'hA5, 8'h5A, 3'(s), 7'h00, s[1], 0);
	endtask
	task automatic t_branch();
		ex(CSB_OP_CMP, 8'h10, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0, 0);
		for (int s = 0; s < 8; s++) begin
			ex(CSB_OP_BR_FLAG_SET, 8'h00, 8'h00, 8'h00, 3'(s), 7'h3F, 1'b0, 0);
			ex(CSB_OP_BR_FLAG_CLR, 8'h00, 8'h00, 8'h00, 3'(s), 7'h40, 1'b0, 0);
		end
		for (int k = 0; k < 2; k++) begin
			ex(CSB_OP_CMP, 8'h10, k ? 8'h10 : 8'h20, 8'h00, 3'h0, 7'h00, 1'b0, 0);
			ex(CSB_OP_BR_EQ, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 0);
			ex(CSB_OP_BR_NE, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7F, 1'b0, 0);
			ex(CSB_OP_BR_CS, 8'h00, 8'h00, 8'h00, 3'h0, 7'h40, 1'b0, 1);
		end
	endtask
	task automatic t_b2b();
		@(negedge CLK_IN);
		ISSUE_IN = 1'b1;
		INSTR_IN = '{op:CSB_OP_CMP, reg_a:8'h80, reg_b:8'h01, io_val:8'h00,
			sel:3'h0, offset:7'h00, next_is_long:1'b0};
		@(negedge CLK_IN);
		INSTR_IN.op = CSB_OP_CMP_IMM;
		INSTR_IN.reg_a = 8'h00;
		@(negedge CLK_IN);
		ISSUE_IN = 1'b0;
		ef = fl(8'h00, 8'h01, 1'b0, 1'b1);
		ep = ep + 16'h0002;
		chk({8'h00, FLAGS_OUT}, {8'h00, ef});
		chk(PC_OUT, ep);
		ex(CSB_OP_NOP, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 0);
	endtask
	task automatic t_reset();
		@(negedge CLK_IN);
		RESETN_IN = 1'b0;
		@(negedge CLK_IN);
		chk(PC_OUT, 16'h0000);
		chk({8'h00, FLAGS_OUT}, 16'h0000);
		chk({14'h0000, READY_OUT, DONE_OUT}, 16'h0002);
		RESETN_IN = 1'b1;
		ep = 16'h0000;
		ef = 8'h00;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		RESETN_IN = 1'b0;
		ISSUE_IN = 1'b0;
		INSTR_IN = '0;
		ep = 16'h0000;
		ef = 8'h00;
		repeat (4) @(posedge CLK_IN);
		@(negedge CLK_IN);
		RESETN_IN = 1'b1;
		t_cmp();
		t_skip();
		t_branch();
		t_b2b();
		t_reset();
		t_branch();
		test_done();
	end
endmodule
`default_nettype wire
